// ---- design/sdl_pkg.sv ----
/*
 * Shared constants for both link ends: timing, widths, code tables.
 * Assumes one 25 MHz clock that is also the transmit reference.
 */
// What this block does
// - enable low powers down, signal detect only
// - powered down: high flag shows signal status
// - enable rising from power-down triggers full reset
// - lock low: receiver follows reference, transmit only
// - lock low and enabled: receive outputs float
// - lock high: receiver tracks incoming data
// - loopback routes transmit internally, serial outputs float
// - pre-emphasis 5 percent low, 20 percent high
// - prbs mode: low flag shows valid pattern
// - low flag marks special code in low byte
// - high flag marks special code in high byte
// - weak input forces word and flags high, except the low flag, which reads low in prbs mode
// - receive clock is bit rate over twenty
// - received word valid at receive clock rise
// - per-byte select chooses special or data code
// - reference clock registers transmit word and selects
// - serial rate is twenty times reference
// - power-on reset floats outputs, clock low
// - power-on reset finishes under one millisecond
// - controller keeps lock high during power-on reset
// - enable low at power-up resets receiver first
// - late lock release held high one microsecond
package sdl_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int POR_TIME_NS = 1000000;
   // one cycle under the limit
   localparam int POR_MAX_CYC = POR_TIME_NS / CLK_PERIOD_NS - 1;
   localparam int LOCK_HOLD_NS = 1000;
   localparam int LOCK_HOLD_CYC = (LOCK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 15;

   // ----------------------------------------
   // widths and reset values
   // ----------------------------------------
   localparam int WORD_W = 16;
   localparam int LINE_W = 20;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [19:0] RST_LINE = 20'h00000;
   localparam logic [15:0] LOS_WORD = 16'hFFFF;
   localparam logic [14:0] RST_CNT = 15'h0000;
   localparam logic [4:0] PRE_LOW_PCT = 5'h05;
   localparam logic [4:0] PRE_HIGH_PCT = 5'h14;

   // ----------------------------------------
   // 8b/10b tables, written in negative-disparity form, bit a first
   // ----------------------------------------
   localparam logic [4:0] K28 = 5'h1C;
   localparam logic [5:0] K28_6B = 6'h0F;
   localparam logic [3:0] ALT7_4B = 4'h7;
   localparam logic [5:0] CODE6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] CODE4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

endpackage

// ---- design/sdl_link_if.sv ----
/*
 * Parallel pins between transceiver and protocol device.
 * Assumes one clock; output enables are low while driving.
 */
interface sdl_link_if
(
   input wire logic clk
);
   // transmit side, driven by the protocol device
   logic [15:0] tx_word;
   logic tx_low_byte_k_select;
   logic tx_high_byte_k_select;
   // mode pins, driven by the protocol device
   logic device_enable;
   logic lock_to_reference_n;
   logic loopback_enable;
   logic prbs_check_enable;
   logic preemphasis_high;
   logic factory_test_select;
   // receive side, driven by the transceiver
   logic [15:0] rx_word;
   logic rx_low_byte_k_flag;
   logic rx_high_byte_k_flag;
   logic recovered_word_clock;
   logic rx_bus_oe_n;
   logic rx_high_flag_oe_n;

   modport dev
   (
      input tx_word, tx_low_byte_k_select, tx_high_byte_k_select,
      input device_enable, lock_to_reference_n, loopback_enable,
      input prbs_check_enable, preemphasis_high, factory_test_select,
      output rx_word, rx_low_byte_k_flag, rx_high_byte_k_flag,
      output recovered_word_clock, rx_bus_oe_n, rx_high_flag_oe_n
   );

   modport proto
   (
      output tx_word, tx_low_byte_k_select, tx_high_byte_k_select,
      output device_enable, lock_to_reference_n, loopback_enable,
      output prbs_check_enable, preemphasis_high, factory_test_select,
      input rx_word, rx_low_byte_k_flag, rx_high_byte_k_flag,
      input recovered_word_clock, rx_bus_oe_n, rx_high_flag_oe_n
   );
endinterface

// ---- design/sdl_serdes_dev.sv ----
/*
 * Transceiver end: 8b/10b coding, power modes, loopback, prbs check.
 * Assumes clk is the reference; line is one 20-bit word per clock.
 */
module sdl_serdes_dev
   import sdl_pkg::*;
#(
   parameter int POR_CYCLES = POR_MAX_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // parallel pins to the protocol device
   sdl_link_if.dev link,
   // serial line, one line word per clock
   output logic [19:0] serial_out_pos,
   output logic [19:0] serial_out_neg,
   output logic serial_out_oe_n,
   input wire logic [19:0] serial_in_pos,
   // analog detector: high while input amplitude is at least 200 mV
   input wire logic signal_detect,
   // drive strength setting for the analog output stage
   output logic [4:0] preemphasis_percent
);

   // ----------------------------------------
   // coding functions
   // ----------------------------------------

   // one byte to one symbol; returns {disparity after, symbol}
   function automatic logic [10:0] enc8b(input logic [7:0] b, input logic k, input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic rdm;
      logic alt;
      logic [4:0] x;
      logic [2:0] y;
      x = b[4:0];
      y = b[7:5];
      c6 = (k && x == K28) ? K28_6B : CODE6[x];
      if (rd && ($countones(c6) != 3 || x == 5'h07))
         c6 = ~c6;
      rdm = rd ^ ($countones(c6) != 3);
      alt = k || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
         || (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
      c4 = (y == 3'h7 && alt) ? ALT7_4B : CODE4[y];
      if (rdm && ($countones(c4) != 2 || y == 3'h3))
         c4 = ~c4;
      else if (k && x == K28 && !rdm && $countones(c4) == 2 && y != 3'h3)
         c4 = ~c4;
      return {rdm ^ ($countones(c4) != 2), c6, c4};
   endfunction

   // only these special characters exist
   function automatic logic k_legal(input logic [7:0] b);
      return b[4:0] == K28 || (b[7:5] == 3'h7 && (b[4:0] == 5'h17 || b[4:0] == 5'h1B
         || b[4:0] == 5'h1D || b[4:0] == 5'h1E));
   endfunction

   // search, tracked disparity first, then the other so a lost step recovers
   function automatic logic [9:0] dec8b(input logic [9:0] code, input logic rd);
      logic [9:0] r;
      logic [10:0] e;
      r = 10'h000;
      for (int i = 0; i < 1024; i++)
      begin
         e = enc8b(i[7:0], i[8], rd ^ i[9]);
         if (!r[9] && (!i[8] || k_legal(i[7:0])) && e[9:0] == code)
            r = {1'b1, i[8], i[7:0]};
      end
      return r;
   endfunction

   // 7-bit pattern, bit 0 first: next 16 bits follow from the last word
   function automatic logic [15:0] prbs_next(input logic [15:0] w);
      logic [31:0] s;
      s = {16'h0000, w};
      for (int i = 16; i < 32; i++)
         s[i] = s[i - 7] ^ s[i - 6];
      return s[31:16];
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {ST_DOWN = 3'h1, ST_POR = 3'h2, ST_RUN = 3'h4} sdl_dev_state_t;

   sdl_dev_state_t state, next_state;
   logic [14:0] por_cnt, next_por_cnt;
   logic [2:0] sd_sync, next_sd_sync;
   logic sig_present, next_sig_present;
   logic [15:0] tx_word_q, next_tx_word_q;
   logic [1:0] tx_k_q, next_tx_k_q;
   logic [19:0] tx_line, next_tx_line;
   logic tx_rd, next_tx_rd;
   logic [19:0] rx_line, next_rx_line;
   logic rx_rd, next_rx_rd;
   logic [15:0] rx_raw, next_rx_raw;
   logic [15:0] rx_word_q, next_rx_word_q;
   logic rx_lo_k, next_rx_lo_k;
   logic rx_hi_k, next_rx_hi_k;
   logic [4:0] pre_q, next_pre_q;

   logic run;
   logic rx_on;
   logic signal_lost_status;
   logic rd_mid;
   logic [9:0] dec_lo;
   logic [9:0] dec_hi;
   logic [10:0] enc_lo;
   logic [10:0] enc_hi;
   logic [15:0] dec_word;
   logic prbs_pass;

   // ----------------------------------------
   // control: power-down, power-on reset, signal detect
   // ----------------------------------------

   // analog detect: three flops, taken when the last two agree
   always_comb
   begin
      next_state = state;
      next_por_cnt = por_cnt;
      next_sd_sync = {sd_sync[1:0], signal_detect};
      next_sig_present = (sd_sync[1] == sd_sync[2]) ? sd_sync[2] : sig_present;
      case (state)
         ST_DOWN:
         begin
            next_por_cnt = RST_CNT;
            if (link.device_enable)
               next_state = ST_POR;
         end
         ST_POR:
         begin
            next_por_cnt = por_cnt + 15'h0001;
            if (!link.device_enable)
               next_state = ST_DOWN;
            else if (por_cnt == 15'(POR_CYCLES - 1))
               next_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (!link.device_enable)
               next_state = ST_DOWN;
         end
         default:
            next_state = ST_DOWN;
      endcase
   end

   // reset clears the receiver whatever enable says
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= ST_DOWN;
         por_cnt <= RST_CNT;
         sd_sync <= 3'h0;
         sig_present <= 1'b0;
      end
      else
      begin
         state <= next_state;
         por_cnt <= next_por_cnt;
         sd_sync <= next_sd_sync;
         sig_present <= next_sig_present;
      end
   end

   // ----------------------------------------
   // datapath
   // ----------------------------------------
   assign run = (state == ST_RUN);
   // lock low: receiver follows reference, not data
   assign rx_on = run && link.lock_to_reference_n;
   // the internal loop always carries signal
   assign signal_lost_status = !sig_present && !link.loopback_enable;

   assign enc_lo = enc8b(tx_word_q[7:0], tx_k_q[0], tx_rd);
   assign enc_hi = enc8b(tx_word_q[15:8], tx_k_q[1], enc_lo[10]);
   assign dec_lo = dec8b(rx_line[19:10], rx_rd);
   assign rd_mid = rx_rd ^ ($countones(rx_line[19:10]) != 5);
   assign dec_hi = dec8b(rx_line[9:0], rd_mid);
   assign dec_word = {dec_hi[7:0], dec_lo[7:0]};
   assign prbs_pass = (dec_word == prbs_next(rx_raw)) && dec_lo[9] && dec_hi[9] && !signal_lost_status;

   always_comb
   begin
      next_tx_word_q = tx_word_q;
      next_tx_k_q = tx_k_q;
      next_tx_line = tx_line;
      next_tx_rd = 1'b0;
      next_rx_line = rx_line;
      next_rx_rd = 1'b0;
      next_rx_raw = rx_raw;
      next_rx_word_q = rx_word_q;
      next_rx_lo_k = rx_lo_k;
      next_rx_hi_k = rx_hi_k;
      next_pre_q = link.preemphasis_high ? PRE_HIGH_PCT : PRE_LOW_PCT;
      if (run)
      begin
         // one line word per reference edge: twenty bits per period
         next_tx_word_q = link.tx_word;
         next_tx_k_q = {link.tx_high_byte_k_select, link.tx_low_byte_k_select};
         next_tx_line = {enc_lo[9:0], enc_hi[9:0]};
         next_tx_rd = enc_hi[10];
         next_rx_rd = rx_rd;
      end
      if (rx_on)
      begin
         next_rx_line = link.loopback_enable ? tx_line : serial_in_pos;
         next_rx_rd = rd_mid ^ ($countones(rx_line[9:0]) != 5);
         next_rx_raw = dec_word;
         next_rx_word_q = signal_lost_status ? LOS_WORD : dec_word;
         next_rx_hi_k = signal_lost_status | dec_hi[8];
         // prbs check owns the low flag
         if (link.prbs_check_enable)
            next_rx_lo_k = prbs_pass;
         else
            next_rx_lo_k = signal_lost_status | dec_lo[8];
      end
      // powered down: the high flag reports loss of signal, low = lost
      if (state == ST_DOWN)
         next_rx_hi_k = sig_present;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         tx_word_q <= RST_WORD;
         tx_k_q <= 2'h0;
         tx_line <= RST_LINE;
         tx_rd <= 1'b0;
         rx_line <= RST_LINE;
         rx_rd <= 1'b0;
         rx_raw <= RST_WORD;
         rx_word_q <= RST_WORD;
         rx_lo_k <= 1'b0;
         rx_hi_k <= 1'b0;
         pre_q <= PRE_LOW_PCT;
      end
      else
      begin
         tx_word_q <= next_tx_word_q;
         tx_k_q <= next_tx_k_q;
         tx_line <= next_tx_line;
         tx_rd <= next_tx_rd;
         rx_line <= next_rx_line;
         rx_rd <= next_rx_rd;
         rx_raw <= next_rx_raw;
         rx_word_q <= next_rx_word_q;
         rx_lo_k <= next_rx_lo_k;
         rx_hi_k <= next_rx_hi_k;
         pre_q <= next_pre_q;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------

   // receive bus floats unless receiving; the high flag is also driven while powered down
   assign link.rx_bus_oe_n = !rx_on;
   assign link.rx_high_flag_oe_n = !(rx_on || state == ST_DOWN);
   assign link.rx_word = rx_word_q;
   assign link.rx_low_byte_k_flag = rx_lo_k;
   assign link.rx_high_byte_k_flag = rx_hi_k;
   // gated clock, low unless receiving (run with lock high); data flops change at its rise
   assign link.recovered_word_clock = clk & rx_on;
   // serial outputs float unless running unlooped
   assign serial_out_oe_n = !(run && !link.loopback_enable);
   assign serial_out_pos = tx_line;
   assign serial_out_neg = ~tx_line;
   assign preemphasis_percent = pre_q;

endmodule // sdl_serdes_dev

// ---- design/sdl_proto_host.sv ----
/*
 * Protocol end: drives transmit and mode pins, samples receive, sequences lock.
 * Assumes the transceiver's clock.
 */
module sdl_proto_host
   import sdl_pkg::*;
#(
   parameter int POR_CYCLES = POR_MAX_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // parallel pins to the transceiver
   sdl_link_if.proto link,
   // user requests
   input wire logic user_enable,
   input wire logic user_tx_only,
   input wire logic user_loopback,
   input wire logic user_prbs_check,
   input wire logic user_pre_high,
   input wire logic [15:0] user_tx_word,
   input wire logic [1:0] user_tx_k,
   // user results
   output logic [15:0] user_rx_word,
   output logic [1:0] user_rx_k,
   output logic user_rx_valid,
   output logic user_signal_ok,
   output logic user_link_ready
);

   typedef enum logic [3:0] {HS_OFF = 4'h1, HS_WAIT = 4'h2, HS_HOLD = 4'h4, HS_FREE = 4'h8} sdl_host_state_t;

   sdl_host_state_t state, next_state;
   logic [14:0] cnt, next_cnt;
   logic [15:0] txw, next_txw;
   logic [1:0] txk, next_txk;
   logic en, next_en;
   logic lock_n, next_lock_n;
   logic loop, next_loop;
   logic prbs, next_prbs;
   logic pre, next_pre;
   logic [15:0] rxw, next_rxw;
   logic [1:0] rxk, next_rxk;
   logic rxv, next_rxv;
   logic sok, next_sok;

   // ----------------------------------------
   // lock sequencing and sampling
   // ----------------------------------------

   // lock high through reset and hold; transmit-only gets loopback for edges
   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 15'h0001;
      next_lock_n = 1'b1;
      next_loop = user_loopback;
      next_en = user_enable;
      next_txw = user_tx_word;
      next_txk = user_tx_k;
      next_prbs = user_prbs_check;
      next_pre = user_pre_high;
      case (state)
         HS_OFF:
         begin
            next_cnt = RST_CNT;
            if (user_enable)
               next_state = HS_WAIT;
         end
         HS_WAIT:
         begin
            next_loop = user_loopback | user_tx_only;
            if (cnt == 15'(POR_CYCLES))
            begin
               next_state = HS_HOLD;
               next_cnt = RST_CNT;
            end
         end
         HS_HOLD:
         begin
            next_loop = user_loopback | user_tx_only;
            if (cnt == 15'(LOCK_HOLD_CYC))
               next_state = HS_FREE;
         end
         HS_FREE:
         begin
            next_cnt = cnt;
            next_lock_n = !user_tx_only;
         end
         default:
            next_state = HS_OFF;
      endcase
      if (!user_enable)
         next_state = HS_OFF;
      // sample at the clock rise only while the bus is driven
      next_rxv = !link.rx_bus_oe_n;
      next_rxw = link.rx_bus_oe_n ? rxw : link.rx_word;
      next_rxk = link.rx_bus_oe_n ? rxk : {link.rx_high_byte_k_flag, link.rx_low_byte_k_flag};
      // while powered down the high flag carries signal status
      next_sok = (!en && !link.rx_high_flag_oe_n) ? link.rx_high_byte_k_flag : sok;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= HS_OFF;
         cnt <= RST_CNT;
         txw <= RST_WORD;
         txk <= 2'h0;
         en <= 1'b0;
         lock_n <= 1'b1;
         loop <= 1'b0;
         prbs <= 1'b0;
         pre <= 1'b0;
         rxw <= RST_WORD;
         rxk <= 2'h0;
         rxv <= 1'b0;
         sok <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         txw <= next_txw;
         txk <= next_txk;
         en <= next_en;
         lock_n <= next_lock_n;
         loop <= next_loop;
         prbs <= next_prbs;
         pre <= next_pre;
         rxw <= next_rxw;
         rxk <= next_rxk;
         rxv <= next_rxv;
         sok <= next_sok;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign link.tx_word = txw;
   assign link.tx_low_byte_k_select = txk[0];
   assign link.tx_high_byte_k_select = txk[1];
   assign link.device_enable = en;
   assign link.lock_to_reference_n = lock_n;
   assign link.loopback_enable = loop;
   assign link.prbs_check_enable = prbs;
   assign link.preemphasis_high = pre;
   // test select must stay low in service
   assign link.factory_test_select = 1'b0;
   assign user_rx_word = rxw;
   assign user_rx_k = rxk;
   assign user_rx_valid = rxv;
   assign user_signal_ok = sok;
   assign user_link_ready = (state == HS_FREE);

endmodule // sdl_proto_host

// ---- verif/sdl_link_checker.sv ----
/*
 * Concurrent checks on the link pins.
 * Assumes one clock and shared synchronous reset.
 */
module sdl_link_checker
   import sdl_pkg::*;
#(
   parameter int POR_CYCLES = POR_MAX_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // protocol end outputs
   input wire logic [15:0] tx_word,
   input wire logic tx_low_byte_k_select,
   input wire logic tx_high_byte_k_select,
   input wire logic device_enable,
   input wire logic lock_to_reference_n,
   input wire logic loopback_enable,
   input wire logic prbs_check_enable,
   // transceiver outputs
   input wire logic [15:0] rx_word,
   input wire logic rx_low_byte_k_flag,
   input wire logic rx_high_byte_k_flag,
   input wire logic recovered_word_clock,
   input wire logic rx_bus_oe_n,
   input wire logic rx_high_flag_oe_n
);
   logic [15:0] on_cnt;
   logic [15:0] next_on_cnt;

   // -------------------------------
   // cycles since enable rose
   // -------------------------------
   // saturates: no wrap into the reset window
   always_comb
   begin
      next_on_cnt = device_enable ? on_cnt + 16'(on_cnt != 16'hFFFF) : 16'h0000;
   end

   always_ff @(posedge clk)
   begin
      on_cnt <= rst_b ? next_on_cnt : 16'h0000;
   end

   // -------------------------------
   // assertions
   // -------------------------------
   a_down_floats_bus: assert property (@(posedge clk) disable iff (!rst_b)
      !device_enable |=> rx_bus_oe_n && !rx_high_flag_oe_n) else $error("receive pins wrong while powered down");
   a_txonly_floats_bus: assert property (@(posedge clk) disable iff (!rst_b)
      device_enable && $past(device_enable) && !lock_to_reference_n |-> rx_bus_oe_n && rx_high_flag_oe_n)
      else $error("receive pins driven in transmit-only mode");
   a_por_min_length: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(rx_bus_oe_n) |-> int'(on_cnt) >= POR_CYCLES) else $error("receive bus driven before reset ended");
   a_por_max_length: assert property (@(posedge clk) disable iff (!rst_b)
      device_enable && lock_to_reference_n && int'(on_cnt) == POR_CYCLES + 3 |-> !rx_bus_oe_n)
      else $error("power-on reset too long");
   a_lock_hold_time: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(lock_to_reference_n) |-> device_enable && int'(on_cnt) >= POR_CYCLES + LOCK_HOLD_CYC)
      else $error("lock released too early");
   a_recovered_word_clock_follows_bus: assert property (@(negedge clk) disable iff (!rst_b)
      recovered_word_clock == !rx_bus_oe_n) else $error("receive clock out of step with bus");
   a_txonly_clock_low: assert property (@(negedge clk) disable iff (!rst_b)
      !lock_to_reference_n |-> !recovered_word_clock) else $error("receive clock runs in transmit-only mode");
   a_loop_word_echo: assert property (@(posedge clk) disable iff (!rst_b)
      (loopback_enable && !prbs_check_enable && !rx_bus_oe_n) [*7] |-> rx_word == $past(tx_word, 4)
      && rx_low_byte_k_flag == $past(tx_low_byte_k_select, 4)
      && rx_high_byte_k_flag == $past(tx_high_byte_k_select, 4)) else $error("looped word differs");
endmodule // sdl_link_checker

// ---- verif/gigabit_serdes_8b10b_port_tb.sv ----
/*
 * Self-checking bench joining both ends.
 * Assumes 25 MHz and a short reset count.
 */
module gigabit_serdes_8b10b_port_tb;
   import sdl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR_SIM = 20;
   localparam logic [17:0] IDLE = 18'h3BCBC; // {k flags, word}, both bytes special
   logic clk = 1'b0;
   logic rst_b, user_enable, user_tx_only, user_loopback, user_prbs_check, user_pre_high, signal_detect, watch;
   logic [15:0] user_tx_word;
   logic [1:0] user_tx_k;
   logic [19:0] serial_in_pos;
   logic [15:0] user_rx_word;
   logic [1:0] user_rx_k;
   logic user_rx_valid, user_signal_ok, user_link_ready, serial_out_oe_n;
   logic [19:0] serial_out_pos;
   logic [4:0] preemphasis_percent;
   logic [17:0] expq[$];
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed = 32'h7C10311F;

   always #20 clk = ~clk;

   sdl_link_if sdl_link_if_inst (.clk(clk));
   sdl_serdes_dev #(.POR_CYCLES(POR_SIM)) sdl_serdes_dev_inst (.clk(clk), .rst_b(rst_b),
      .link(sdl_link_if_inst), .serial_out_pos(serial_out_pos), .serial_out_neg(),
      .serial_out_oe_n(serial_out_oe_n), .serial_in_pos(serial_in_pos), .signal_detect(signal_detect),
      .preemphasis_percent(preemphasis_percent));
   sdl_proto_host #(.POR_CYCLES(POR_SIM)) sdl_proto_host_inst (.clk(clk), .rst_b(rst_b),
      .link(sdl_link_if_inst), .user_enable(user_enable), .user_tx_only(user_tx_only),
      .user_loopback(user_loopback), .user_prbs_check(user_prbs_check), .user_pre_high(user_pre_high),
      .user_tx_word(user_tx_word), .user_tx_k(user_tx_k), .user_rx_word(user_rx_word), .user_rx_k(user_rx_k),
      .user_rx_valid(user_rx_valid), .user_signal_ok(user_signal_ok), .user_link_ready(user_link_ready));
   sdl_link_checker #(.POR_CYCLES(POR_SIM)) sdl_link_checker_inst (.clk(clk), .rst_b(rst_b),
      .tx_word(sdl_link_if_inst.tx_word), .tx_low_byte_k_select(sdl_link_if_inst.tx_low_byte_k_select),
      .tx_high_byte_k_select(sdl_link_if_inst.tx_high_byte_k_select),
      .device_enable(sdl_link_if_inst.device_enable), .lock_to_reference_n(sdl_link_if_inst.lock_to_reference_n),
      .loopback_enable(sdl_link_if_inst.loopback_enable), .prbs_check_enable(sdl_link_if_inst.prbs_check_enable),
      .rx_word(sdl_link_if_inst.rx_word), .rx_low_byte_k_flag(sdl_link_if_inst.rx_low_byte_k_flag),
      .rx_high_byte_k_flag(sdl_link_if_inst.rx_high_byte_k_flag),
      .recovered_word_clock(sdl_link_if_inst.recovered_word_clock),
      .rx_bus_oe_n(sdl_link_if_inst.rx_bus_oe_n), .rx_high_flag_oe_n(sdl_link_if_inst.rx_high_flag_oe_n));

   // -------------------------------
   // compare and closing tasks
   // -------------------------------
   task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // bounded wait for lock sequencing
   task automatic wait_ready();
      int n;
      n = 0;
      while (user_link_ready !== 1'b1 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      check_bit(user_link_ready, 1'b1);
   endtask

   // random words back to back, K28.7 avoided
   task automatic burst(input int n);
      logic [17:0] w;
      int r;
      for (int i = 0; i < n; i++)
      begin
         r = $random(seed);
         w = r[17:0];
         if (w[16])
            w[7:0] = {(r[7:5] == 3'h7) ? 3'h5 : r[7:5], 5'h1C};
         if (w[17])
            w[15:8] = {(r[15:13] == 3'h7) ? 3'h0 : r[15:13], 5'h1C};
         if (w == IDLE)
            w[15:8] = 8'h1C;
         @(posedge clk);
         user_tx_word <= w[15:0];
         user_tx_k <= w[17:16];
         expq.push_back(w);
      end
      @(posedge clk);
      user_tx_word <= IDLE[15:0];
      user_tx_k <= IDLE[17:16];
      tick(12);
      check_bit(expq.size() == 0, 1'b1);
   endtask

   // -------------------------------
   // watchers
   // -------------------------------
   // idle filler is skipped, only pushed words pop
   always @(posedge clk)
   begin
      cyc++;
      serial_in_pos <= {serial_in_pos[18:0], ~serial_in_pos[19]};
      if (watch && user_rx_valid === 1'b1 && {user_rx_k, user_rx_word} !== IDLE)
         check_word({user_rx_k, user_rx_word}, (expq.size() == 0) ? IDLE : expq.pop_front());
      if (cyc == 3000)
      begin
         fail_count++;
         $display("unexpected at %0t: run took too long", $time);
         print_verdict();
      end
   end

   // -------------------------------
   // main sequence
   // -------------------------------
   initial
   begin
      rst_b = 1'b0;
      {user_enable, user_tx_only, user_prbs_check, user_pre_high, watch} = 5'h00;
      user_loopback = 1'b1;
      signal_detect = 1'b1;
      {user_tx_k, user_tx_word} = IDLE;
      serial_in_pos = 20'h0F0F3;
      tick(3);
      rst_b <= 1'b1;
      tick(6);
      check_bit(sdl_link_if_inst.rx_bus_oe_n, 1'b1);
      check_bit(sdl_link_if_inst.rx_high_byte_k_flag, 1'b1);
      signal_detect <= 1'b0;
      tick(6);
      check_bit(sdl_link_if_inst.rx_high_byte_k_flag, 1'b0);
      signal_detect <= 1'b1;
      for (int p = 0; p < 2; p++)
      begin
         user_pre_high <= p[0];
         tick(5);
         check_word(18'(preemphasis_percent), p[0] ? 18'(PRE_HIGH_PCT) : 18'(PRE_LOW_PCT));
      end
      check_bit(user_signal_ok, 1'b1);
      $display("done: power-down and pre-emphasis");
      user_enable <= 1'b1;
      tick(4);
      check_bit(serial_out_oe_n, 1'b1);
      wait_ready();
      watch <= 1'b1;
      burst(40);
      watch <= 1'b0;
      $display("done: loopback burst");
      user_loopback <= 1'b0;
      signal_detect <= 1'b0;
      tick(8);
      check_word({sdl_link_if_inst.rx_high_byte_k_flag, sdl_link_if_inst.rx_low_byte_k_flag,
         sdl_link_if_inst.rx_word}, 18'h3FFFF);
      check_bit(serial_out_oe_n, 1'b0);
      user_loopback <= 1'b1;
      signal_detect <= 1'b1;
      user_prbs_check <= 1'b1;
      tick(8);
      check_bit(sdl_link_if_inst.rx_low_byte_k_flag, 1'b0);
      user_prbs_check <= 1'b0;
      tick(8);
      check_bit(sdl_link_if_inst.rx_low_byte_k_flag, 1'b1);
      $display("done: signal loss and pattern check");
      user_tx_only <= 1'b1;
      tick(6);
      check_bit(sdl_link_if_inst.rx_bus_oe_n, 1'b1);
      check_bit(sdl_link_if_inst.rx_high_flag_oe_n, 1'b1);
      user_tx_only <= 1'b0;
      tick(6);
      check_bit(sdl_link_if_inst.rx_bus_oe_n, 1'b0);
      $display("done: transmit-only mode");
      user_enable <= 1'b0;
      tick(4);
      user_enable <= 1'b1;
      tick(4);
      check_bit(sdl_link_if_inst.rx_bus_oe_n, 1'b1);
      wait_ready();
      watch <= 1'b1;
      burst(30);
      watch <= 1'b0;
      $display("done: re-enable and second burst");
      print_verdict();
   end
endmodule // gigabit_serdes_8b10b_port_tb
